//--- rtl/etd_dma.sv
// transmit descriptor dma: fetches ring descriptors, streams buffers to the mac
// assumes a single-request memory port acknowledged by a one-cycle pulse
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
// Functional notes
// - read-only buffer read monitor register, resets to zero, ignores writes.
// - read-only descriptor fetch monitor register, resets to zero, ignores writes.
// - monitor values are informative and may lag actual progress.
// - moves transmit data from memory buffers to the mac without cpu help.
// - fetches descriptors itself, then reads the buffer they point to.
// - steps through consecutive descriptors so frames go out back to back.
// - a frame may sit in one buffer or span several descriptors.
// - descriptor word 0 carries the frame transmit status; the write-back here only clears its active bit and writes no status.
// - active flag cleared by write-back on completion or suspension.
// - inactive fetched descriptor stops transmission until restart.
// - active fetched descriptor is transmitted.
// - last-in-list flag sends the engine back to the first descriptor.
// - bits 29:28 give buffer position: middle, end, start, whole.
// - word 1 upper half gives the valid byte count.
// - word 2 holds the 32-bit buffer start address.
module etd_dma
   import etd_pkg::*;
#(
   parameter int DESC_BYTES = ETD_DESC_BYTES
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output logic mac_valid,
   output logic [31:0] mac_data,
   output logic [2:0] mac_bytes,
   output logic mac_sof,
   output logic mac_eof,
   input wire logic mac_ready
);
   import etd_pkg::*;

   etd_state_t st;
   logic [31:0] list_base;
   logic [31:0] desc_ptr;
   logic [31:0] next_desc;
   logic [31:0] word0;
   logic [15:0] buf_len;
   logic [31:0] cur;
   logic [15:0] rem;
   logic first;
   logic halted;
   logic stop_pend;
   logic [31:0] buf_mon;
   logic [31:0] desc_mon;
   logic apb_wr;
   logic start_req;
   logic mac_take;
   logic [2:0] take_n;

   // bytes carried by the next word, 1 to 4
   function automatic logic [2:0] lanes(input logic [15:0] left);
      lanes = (left >= 16'h0004) ? 3'h4 : left[2:0];
   endfunction : lanes

   assign apb_wr = psel && penable && pready && pwrite;
   assign start_req = apb_wr && (paddr == ETD_OFF_CTRL) && pwdata[ETD_CTRL_START];
   assign mac_take = mac_valid && mac_ready;
   assign take_n = lanes(rem);
   assign next_desc = word0[ETD_D0_LAST] ? list_base : desc_ptr + 32'(DESC_BYTES);

   // apb slave: one wait state, answer registered
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         prdata <= ETD_RESET_WORD;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         prdata <= ETD_RESET_WORD;
         pslverr <= 1'b0;
         if (psel && penable && !pready) begin
            unique case (paddr)
               ETD_OFF_CTRL: prdata <= ETD_RESET_WORD;
               ETD_OFF_LIST_BASE: prdata <= list_base;
               ETD_OFF_STATUS: begin
                  prdata[ETD_STAT_RUN] <= (st != ETD_S_IDLE);
                  prdata[ETD_STAT_HALT] <= halted;
               end
               ETD_OFF_BUF_MON: prdata <= pwrite ? ETD_RESET_WORD : buf_mon;
               ETD_OFF_DESC_MON: prdata <= pwrite ? ETD_RESET_WORD : desc_mon;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         list_base <= ETD_RESET_WORD;
      end else if (apb_wr && paddr == ETD_OFF_LIST_BASE) begin
         list_base <= pwdata;
      end
   end

   // stop only meaningful while busy; a stale stop must not kill the next start
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stop_pend <= 1'b0;
      end else if (st == ETD_S_IDLE) begin
         stop_pend <= 1'b0;
      end else if (apb_wr && paddr == ETD_OFF_CTRL && pwdata[ETD_CTRL_STOP]) begin
         stop_pend <= 1'b1;
      end
   end

   // halt flag: hardware set wins over the clearing start
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         halted <= 1'b0;
      end else if (st == ETD_S_F0 && mem_ack && !mem_rdata[ETD_D0_ACTIVE]) begin
         halted <= 1'b1;
      end else if (start_req) begin
         halted <= 1'b0;
      end
   end

   // main sequencer and memory port
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st <= ETD_S_IDLE;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= ETD_RESET_WORD;
         mem_wdata <= ETD_RESET_WORD;
         desc_ptr <= ETD_RESET_WORD;
         word0 <= ETD_RESET_WORD;
         buf_len <= 16'h0000;
         cur <= ETD_RESET_WORD;
         rem <= 16'h0000;
         first <= 1'b0;
      end else begin
         unique case (st)
            ETD_S_IDLE: begin
               if (start_req) begin
                  st <= ETD_S_F0;
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_addr <= desc_ptr;
               end else if (apb_wr && paddr == ETD_OFF_LIST_BASE) begin
                  desc_ptr <= pwdata;
               end
            end
            ETD_S_F0: begin
               if (mem_ack) begin
                  word0 <= mem_rdata;
                  if (mem_rdata[ETD_D0_ACTIVE]) begin
                     st <= ETD_S_F1;
                     mem_addr <= desc_ptr + ETD_W1_OFF;
                  end else begin
                     st <= ETD_S_IDLE;
                     mem_req <= 1'b0;
                  end
               end
            end
            ETD_S_F1: begin
               if (mem_ack) begin
                  buf_len <= mem_rdata[ETD_D1_LEN_MSB:ETD_D1_LEN_LSB];
                  st <= ETD_S_F2;
                  mem_addr <= desc_ptr + ETD_W2_OFF;
               end
            end
            ETD_S_F2: begin
               if (mem_ack) begin
                  cur <= mem_rdata;
                  rem <= buf_len;
                  first <= 1'b1;
                  if (buf_len == 16'h0000) begin
                     st <= ETD_S_WB;
                     mem_we <= 1'b1;
                     mem_addr <= desc_ptr;
                     mem_wdata <= word0 & ~(32'h1 << ETD_D0_ACTIVE);
                  end else begin
                     st <= ETD_S_RD;
                     mem_addr <= mem_rdata;
                  end
               end
            end
            ETD_S_RD: begin
               if (mem_ack) begin
                  st <= ETD_S_TX;
                  mem_req <= 1'b0;
               end
            end
            ETD_S_TX: begin
               if (mac_take) begin
                  cur <= cur + ETD_WORD_BYTES;
                  rem <= rem - 16'(take_n);
                  first <= 1'b0;
                  mem_req <= 1'b1;
                  if (rem == 16'(take_n) || stop_pend) begin
                     st <= ETD_S_WB;
                     mem_we <= 1'b1;
                     mem_addr <= desc_ptr;
                     mem_wdata <= word0 & ~(32'h1 << ETD_D0_ACTIVE);
                  end else begin
                     st <= ETD_S_RD;
                     mem_addr <= cur + ETD_WORD_BYTES;
                  end
               end
            end
            ETD_S_WB: begin
               if (mem_ack) begin
                  mem_we <= 1'b0;
                  desc_ptr <= next_desc;
                  if (stop_pend) begin
                     st <= ETD_S_IDLE;
                     mem_req <= 1'b0;
                  end else begin
                     st <= ETD_S_F0;
                     mem_addr <= next_desc;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mac_valid <= 1'b0;
         mac_data <= ETD_RESET_WORD;
         mac_bytes <= 3'h0;
         mac_sof <= 1'b0;
         mac_eof <= 1'b0;
      end else if (st == ETD_S_RD && mem_ack) begin
         mac_valid <= 1'b1;
         mac_data <= mem_rdata;
         mac_bytes <= take_n;
         mac_sof <= first && word0[ETD_D0_POS_HI];
         mac_eof <= (rem <= 16'h0004) && word0[ETD_D0_POS_LO];
      end else if (mac_take) begin
         mac_valid <= 1'b0;
      end
   end

   // monitors follow issued requests, one cycle late
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         buf_mon <= ETD_RESET_WORD;
         desc_mon <= ETD_RESET_WORD;
      end else begin
         if (st == ETD_S_RD && mem_req) begin
            buf_mon <= mem_addr;
         end
         if (st == ETD_S_F0 && mem_req) begin
            desc_mon <= mem_addr;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_wb_done;
      st == ETD_S_WB && mem_ack;
   endsequence
   sequence s_f0_ack;
      st == ETD_S_F0 && mem_ack;
   endsequence

   property p_buf_mon;
      st == ETD_S_RD && mem_req |=> buf_mon == $past(mem_addr);
   endproperty
   a_buf_mon: assert property (p_buf_mon) else $error("buffer monitor stale");
   property p_desc_mon;
      st == ETD_S_F0 && mem_req |=> desc_mon == $past(mem_addr);
   endproperty
   a_desc_mon: assert property (p_desc_mon) else $error("descriptor monitor stale");
   property p_stop;
      s_f0_ack ##0 !mem_rdata[ETD_D0_ACTIVE] |=> st == ETD_S_IDLE && halted && !mem_req;
   endproperty
   a_stop: assert property (p_stop) else $error("inactive descriptor not stopping");
   property p_go;
      s_f0_ack ##0 mem_rdata[ETD_D0_ACTIVE] |=> st == ETD_S_F1 && mem_addr == desc_ptr + 32'h4;
   endproperty
   a_go: assert property (p_go) else $error("active descriptor not processed");
   property p_wb_clear;
      mem_req && mem_we |-> !mem_wdata[ETD_D0_ACTIVE] && mem_addr == desc_ptr;
   endproperty
   a_wb_clear: assert property (p_wb_clear) else $error("write-back keeps active flag");
   property p_ring;
      s_wb_done ##0 word0[ETD_D0_LAST] |=> desc_ptr == list_base;
   endproperty
   a_ring: assert property (p_ring) else $error("ring did not wrap");
   property p_step;
      s_wb_done ##0 !word0[ETD_D0_LAST] |=> desc_ptr == $past(desc_ptr) + 32'(DESC_BYTES);
   endproperty
   a_step: assert property (p_step) else $error("descriptor step wrong");
   property p_len;
      st == ETD_S_F2 && mem_ack |=> rem == $past(buf_len) && cur == $past(mem_rdata);
   endproperty
   a_len: assert property (p_len) else $error("length or address not loaded");
   property p_restart;
      st == ETD_S_IDLE && start_req |=> st == ETD_S_F0 && mem_addr == $past(desc_ptr);
   endproperty
   a_restart: assert property (p_restart) else $error("restart skipped refetch");
   property p_sof;
      $rose(mac_valid) && mac_sof |-> word0[ETD_D0_POS_HI];
   endproperty
   a_sof: assert property (p_sof) else $error("start mark on middle buffer");
endmodule : etd_dma

//--- rtl/etd_pkg.sv
// constants, descriptor layout and states of the transmit descriptor engine
// assumes a 32-bit memory bus and a 32-bit apb register bus
package etd_pkg;
   // register byte offsets
   localparam logic [7:0] ETD_OFF_CTRL = 8'h00;
   localparam logic [7:0] ETD_OFF_LIST_BASE = 8'h04;
   localparam logic [7:0] ETD_OFF_STATUS = 8'h08;
   localparam logic [7:0] ETD_OFF_BUF_MON = 8'h0C;
   localparam logic [7:0] ETD_OFF_DESC_MON = 8'h10;
   // control and status bits
   localparam int ETD_CTRL_START = 0;
   localparam int ETD_CTRL_STOP = 1;
   localparam int ETD_STAT_RUN = 0;
   localparam int ETD_STAT_HALT = 1;
   // descriptor word 0 fields
   localparam int ETD_D0_ACTIVE = 31;
   localparam int ETD_D0_LAST = 30;
   localparam int ETD_D0_POS_HI = 29;
   localparam int ETD_D0_POS_LO = 28;
   // descriptor word 1 length field
   localparam int ETD_D1_LEN_MSB = 31;
   localparam int ETD_D1_LEN_LSB = 16;
   // word offsets inside a descriptor
   localparam logic [31:0] ETD_W1_OFF = 32'h0000_0004;
   localparam logic [31:0] ETD_W2_OFF = 32'h0000_0008;
   localparam logic [31:0] ETD_WORD_BYTES = 32'h0000_0004;
   localparam logic [31:0] ETD_RESET_WORD = 32'h0000_0000;
   localparam int ETD_DESC_BYTES = 16;
   typedef enum logic [2:0] {
      ETD_S_IDLE,
      ETD_S_F0,
      ETD_S_F1,
      ETD_S_F2,
      ETD_S_RD,
      ETD_S_TX,
      ETD_S_WB
   } etd_state_t;
endpackage : etd_pkg

//--- verif/etd_mem_model.sv
// memory and mac sink model facing the transmit descriptor engine
// assumes one word per request, acknowledged by a one-cycle pulse
`timescale 1ns/1ns
module etd_mem_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   input wire logic mac_valid,
   input wire logic [31:0] mac_data,
   input wire logic [2:0] mac_bytes,
   input wire logic mac_sof,
   input wire logic mac_eof,
   output logic mac_ready
);
   logic [31:0] mem [0:63];
   logic [31:0] q_data [$];
   logic [4:0] q_info [$];
   logic [1:0] wait_cnt;
   logic [31:0] last_rd;
   // slow mode stalls both the memory and the mac sink
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mem_ack <= 1'b0;
         wait_cnt <= 2'h0;
         last_rd <= 32'h0;
         mac_ready <= 1'b0;
      end else begin
         mac_ready <= slow ? ~mac_ready : 1'b1;
         if (mac_valid && mac_ready) begin
            q_data.push_back(mac_data);
            q_info.push_back({mac_bytes, mac_sof, mac_eof});
         end
         mem_ack <= 1'b0;
         if (mem_ack) begin
            wait_cnt <= 2'h0;
            last_rd <= mem_rdata;
            if (mem_we) begin
               mem[mem_addr[7:2]] <= mem_wdata;
            end
         end else if (mem_req && (!slow || wait_cnt == 2'h3)) begin
            mem_ack <= 1'b1;
         end else if (mem_req) begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
   // data is only valid with the ack; otherwise show a changed value
   assign mem_rdata = mem_ack ? mem[mem_addr[7:2]] : ~last_rd;
endmodule : etd_mem_model

//--- verif/tb.sv
// testbench for the transmit descriptor engine over apb
// assumes the memory and mac sink model beside it
`timescale 1ns/1ns
module tb;
   import etd_pkg::*;
   logic clock = 1'b0;
   logic nrst, psel, penable, pwrite, pready, pslverr, slow, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic mem_req, mem_we, mem_ack, mac_valid, mac_sof, mac_eof, mac_ready;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, mac_data;
   logic [2:0] mac_bytes;
   int num_errors = 0;
   int total_checks = 0;
   always #5 clock = ~clock;
   etd_dma #(.DESC_BYTES(16)) i_etd_dma (.clock(clock), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .mac_valid(mac_valid), .mac_data(mac_data), .mac_bytes(mac_bytes), .mac_sof(mac_sof),
      .mac_eof(mac_eof), .mac_ready(mac_ready));
   etd_mem_model u_mem (.clock(clock), .nrst(nrst), .slow(slow), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .mac_valid(mac_valid), .mac_data(mac_data),
      .mac_bytes(mac_bytes), .mac_sof(mac_sof), .mac_eof(mac_eof), .mac_ready(mac_ready));
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors = num_errors + 1;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rd_chk
   // poll status until it shows want (halted by default), bounded
   task automatic wait_halt(input logic [1:0] want = 2'b10);
      int n;
      n = 0;
      do begin
         apb(1'b0, ETD_OFF_STATUS, 32'h0);
         n = n + 1;
      end while (rd[1:0] !== want && n < 60);
      check({30'h0, rd[1:0]}, {30'h0, want});
      // only a real timeout ends the run early, never a late but good answer
      if (rd[1:0] !== want) begin
         give_verdict();
      end
   endtask : wait_halt
   task automatic mac_chk(input logic [31:0] d, input int b, input logic s, input logic e);
      logic [31:0] m;
      m = 32'hFFFF_FFFF >> (8 * (4 - b));
      if (u_mem.q_data.size() == 0) begin
         check(32'h0, 32'h1);
      end else begin
         check(u_mem.q_data.pop_front() & m, d & m);
         check({27'h0, u_mem.q_info.pop_front()}, {27'h0, 3'(b), s, e});
      end
   endtask : mac_chk
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slow = 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      rd_chk(ETD_OFF_BUF_MON, 32'h0);
      rd_chk(ETD_OFF_DESC_MON, 32'h0);
      apb(1'b1, ETD_OFF_BUF_MON, 32'hFFFF_FFFF);
      apb(1'b1, ETD_OFF_DESC_MON, 32'hFFFF_FFFF);
      rd_chk(ETD_OFF_BUF_MON, 32'h0);
      rd_chk(ETD_OFF_DESC_MON, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      u_mem.mem[32] = 32'h4433_2211;
      u_mem.mem[36] = 32'h8877_6655;
      u_mem.mem[37] = 32'hCCBB_AA99;
      u_mem.mem[16] = 32'hA000_0000;
      u_mem.mem[17] = 32'h0004_0000;
      u_mem.mem[18] = 32'h0000_0080;
      u_mem.mem[20] = 32'hD000_0000;
      u_mem.mem[21] = 32'h0005_0000;
      u_mem.mem[22] = 32'h0000_0090;
      apb(1'b1, ETD_OFF_LIST_BASE, 32'h0000_0040);
      apb(1'b1, ETD_OFF_CTRL, 32'h1);
      wait_halt();
      mac_chk(32'h4433_2211, 4, 1'b1, 1'b0);
      mac_chk(32'h8877_6655, 4, 1'b0, 1'b0);
      mac_chk(32'hCCBB_AA99, 1, 1'b0, 1'b1);
      check(u_mem.mem[16], 32'h2000_0000);
      check(u_mem.mem[20], 32'h5000_0000);
      rd_chk(ETD_OFF_DESC_MON, 32'h0000_0040);
      rd_chk(ETD_OFF_BUF_MON, 32'h0000_0094);
      slow <= 1'b1;
      u_mem.mem[16] = 32'hB000_0000;
      u_mem.mem[17] = 32'h0002_0000;
      apb(1'b1, ETD_OFF_CTRL, 32'h1);
      wait_halt();
      mac_chk(32'h4433_2211, 2, 1'b1, 1'b1);
      check(u_mem.mem[16], 32'h3000_0000);
      rd_chk(ETD_OFF_DESC_MON, 32'h0000_0050);
      rd_chk(ETD_OFF_BUF_MON, 32'h0000_0080);
      check(32'(u_mem.q_data.size()), 32'h0);
      // stop while busy: one word out, write-back, idle without halt
      u_mem.mem[16] = 32'hB000_0000;
      u_mem.mem[17] = 32'h000C_0000;
      apb(1'b1, ETD_OFF_LIST_BASE, 32'h0000_0040);
      rd_chk(ETD_OFF_LIST_BASE, 32'h0000_0040);
      apb(1'b1, ETD_OFF_CTRL, 32'h1);
      apb(1'b1, ETD_OFF_CTRL, 32'h2);
      wait_halt(2'b00);
      mac_chk(32'h4433_2211, 4, 1'b1, 1'b0);
      check(u_mem.mem[16], 32'h3000_0000);
      check(32'(u_mem.q_data.size()), 32'h0);
      rd_chk(ETD_OFF_DESC_MON, 32'h0000_0040);
      // restart after the stop resumes at the next, inactive descriptor
      apb(1'b1, ETD_OFF_CTRL, 32'h1);
      wait_halt();
      rd_chk(ETD_OFF_DESC_MON, 32'h0000_0050);
      check(32'(u_mem.q_data.size()), 32'h0);
      give_verdict();
   end
endmodule : tb
